//--- hw/gyro_consts.svh
/*
  Register indices, field positions, masks and reset values of the
  rate-sensor two-wire register port.
  Assumes inclusion by bare name from the port's design file.
*/
`ifndef GYRO_CONSTS_SVH
`define GYRO_CONSTS_SVH

// ---------------------------------------------------------------
// register indices
// ---------------------------------------------------------------
`define IDX_ID        8'h00
`define IDX_SRATE     8'h15
`define IDX_FILTER    8'h16
`define IDX_INTCFG    8'h17
`define IDX_FLAGS     8'h1A
`define IDX_TEMP_H    8'h1B
`define IDX_TEMP_L    8'h1C
`define IDX_RX_H      8'h1D
`define IDX_RX_L      8'h1E
`define IDX_RY_H      8'h1F
`define IDX_RY_L      8'h20
`define IDX_RZ_H      8'h21
`define IDX_RZ_L      8'h22
`define IDX_POWER     8'h3E
`define IDX_HOLD_LO   8'h23
`define IDX_HOLD_HI   8'h3C

// ---------------------------------------------------------------
// fields and masks
// ---------------------------------------------------------------
`define FILTER_MASK   8'h1F
`define INTCFG_MASK   8'hF5
`define ANYRD_BIT     4
`define RAW_EN_BIT    0
`define PLL_EN_BIT    2
`define RAW_FLAG_BIT  0
`define PLL_FLAG_BIT  2
`define BYTE_BITS     4'h8
`define CFG_RESET     8'h00

`endif

//--- hw/gyro_pkg.sv
/*
  Types of the rate-sensor two-wire register port.
  Assumes the constants header is included by the user of the types.
*/
package gyro_pkg;

  typedef enum logic [2:0] {
    PS_IDLE, PS_ADDR, PS_ADDR_ACK, PS_RX, PS_RX_ACK, PS_TX, PS_TX_ACK, PS_WAIT
  } port_state_e;

  typedef struct packed {
    logic [15:0] temp;
    logic [15:0] rateX;
    logic [15:0] rateY;
    logic [15:0] rateZ;
  } sensor_data_s;

  typedef struct packed {
    logic [7:0] sampleDiv;
    logic [7:0] filterCfg;
    logic [7:0] intCfg;
    logic [7:0] powerCtl;
  } config_s;

  typedef struct packed {
    logic [1:0]  sclSync;
    logic [1:0]  sdaSync;
    logic [1:0]  adSync;
    logic        sclPrev;
    logic        sdaPrev;
    port_state_e state;
    logic [3:0]  bitCnt;
    logic [7:0]  shift;
    logic [7:0]  txShift;
    logic [7:0]  index;
    logic        rw;
    logic        firstByte;
    logic        hostAck;
    logic        sdaOe;
    logic        sclOe;
    logic        busy;
    logic [5:0]  idHigh;
    config_s     cfg;
    logic [7:0]  flags;
  } port_state_s;

endpackage

//--- hw/gyro_i2c_register_port.sv
/*
  Two-wire target port with the register map of a three-axis rate sensor.
  Assumes open-drain pins resolved outside, sensor words and event pulses
  on clk_sys, and the controller keeping its side of the protocol.
*/
// Notes on behaviour
// - a falling data line while clock is high starts a frame and resets bit framing.
// - bus is busy from start until stop; a repeated start keeps it busy.
// - bytes are eight bits, any number per transfer, each followed by an acknowledge bit.
// - receiver acknowledges by holding data low through the ninth clock high phase.
// - target may hold the clock low while busy; controller waits for release.
// - write sequence stores the data byte at the indexed register.
// - further written bytes go to successive registers, index incremented after each.
// - read: index written, repeated start with read bit, target drives indexed byte.
// - controller not-acknowledge ends a read; target releases the data line.
// - controller acknowledge of a read byte advances index and sends the next byte.
// - repeated start to another address leaves the target unaddressed.
// - address is six identity bits above the address-select pin level.
// - burst index stops advancing on reaching the reserved range.
// - flags clear on status read, or on any read when clear_on_any_read is set.
`timescale 1ns/1ps
`default_nettype none
`include "gyro_consts.svh"

module gyro_i2c_register_port
  import gyro_pkg::*;
#(
  parameter logic [5:0] ID_HIGH_DEFAULT = 6'h2A  // arbitrary identity value
) (
  input  wire logic         clk_sys,           // 200 MHz system clock
  input  wire logic         rst,               // async reset, active high
  input  wire logic         sclIn,             // clock pin level
  output logic              sclOut,            // clock pin drive value
  output logic              sclOe,             // clock pin pulled low
  input  wire logic         sdaIn,             // data pin level
  output logic              sdaOut,            // data pin drive value
  output logic              sdaOe,             // data pin pulled low
  input  wire logic         addressSelectPin,  // address low bit strap
  input  wire logic         stretchRequest,    // device not ready, hold clock
  input  wire sensor_data_s sensor,            // latest sensor words
  input  wire logic         dataReadyEvent,    // new sample pulse
  input  wire logic         pllReadyEvent,     // clock source locked pulse
  output config_s           cfgOut,            // configuration registers
  output logic [7:0]        interruptFlags,    // flag register
  output logic              busBusy            // between start and stop
);

  port_state_s s;
  port_state_s n;

  logic sclNow;
  logic sdaNow;
  logic sclRise;
  logic sclFall;
  logic startCond;
  logic stopCond;
  logic [6:0] ownAddr;
  logic [7:0] idxInc;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [7:0] nextIndex(input logic [7:0] idx);
    if (idx >= `IDX_HOLD_LO && idx <= `IDX_HOLD_HI)
      return idx;
    return idx + 8'h01;
  endfunction

  function automatic logic [7:0] readByte(input port_state_s st,
                                          input sensor_data_s sd,
                                          input logic [7:0] idx);
    case (idx)
      `IDX_ID:     return {1'b0, st.idHigh, 1'b0};
      `IDX_SRATE:  return st.cfg.sampleDiv;
      `IDX_FILTER: return st.cfg.filterCfg;
      `IDX_INTCFG: return st.cfg.intCfg;
      `IDX_FLAGS:  return st.flags;
      `IDX_TEMP_H: return sd.temp[15:8];
      `IDX_TEMP_L: return sd.temp[7:0];
      `IDX_RX_H:   return sd.rateX[15:8];
      `IDX_RX_L:   return sd.rateX[7:0];
      `IDX_RY_H:   return sd.rateY[15:8];
      `IDX_RY_L:   return sd.rateY[7:0];
      `IDX_RZ_H:   return sd.rateZ[15:8];
      `IDX_RZ_L:   return sd.rateZ[7:0];
      `IDX_POWER:  return st.cfg.powerCtl;
      default:     return 8'h00;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // line conditions
  // ---------------------------------------------------------------
  assign sclNow    = s.sclSync[1];
  assign sdaNow    = s.sdaSync[1];
  assign sclRise   = sclNow & ~s.sclPrev;
  assign sclFall   = ~sclNow & s.sclPrev;
  assign startCond = sclNow & s.sclPrev & s.sdaPrev & ~sdaNow;
  assign stopCond  = sclNow & s.sclPrev & ~s.sdaPrev & sdaNow;
  assign ownAddr   = {s.idHigh, s.adSync[1]};
  assign idxInc    = nextIndex(s.index);

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic       rdEv;
    logic [7:0] rdIdx;
    logic [7:0] txByte;
    rdEv   = 1'b0;
    rdIdx  = s.index;
    txByte = 8'h00;
    n = s;
    n.sclSync = {s.sclSync[0], sclIn};
    n.sdaSync = {s.sdaSync[0], sdaIn};
    n.adSync  = {s.adSync[0], addressSelectPin};
    n.sclPrev = sclNow;
    n.sdaPrev = sdaNow;
    if (startCond) begin
      n.state  = PS_ADDR;
      n.bitCnt = 4'h0;
      n.busy   = 1'b1;
      n.sdaOe  = 1'b0;
    end else if (stopCond) begin
      n.state = PS_IDLE;
      n.busy  = 1'b0;
      n.sdaOe = 1'b0;
    end else if (sclRise) begin
      case (s.state)
        PS_ADDR, PS_RX: begin
          n.shift  = {s.shift[6:0], sdaNow};
          n.bitCnt = s.bitCnt + 4'h1;
        end
        PS_TX:     n.bitCnt = s.bitCnt + 4'h1;
        PS_TX_ACK: n.hostAck = ~sdaNow;
        default: ;
      endcase
    end else if (sclFall) begin
      case (s.state)
        PS_ADDR: begin
          if (s.bitCnt == `BYTE_BITS) begin
            if (s.shift[7:1] == ownAddr) begin
              n.rw    = s.shift[0];
              n.sdaOe = 1'b1;
              n.state = PS_ADDR_ACK;
            end else begin
              n.state = PS_IDLE;
            end
          end
        end
        PS_ADDR_ACK: begin
          n.bitCnt = 4'h0;
          if (s.rw) begin
            txByte    = readByte(s, sensor, s.index);
            rdEv      = 1'b1;
            n.txShift = txByte;
            n.sdaOe   = ~txByte[7];
            n.state   = PS_TX;
          end else begin
            n.sdaOe     = 1'b0;
            n.firstByte = 1'b1;
            n.state     = PS_RX;
          end
        end
        PS_RX: begin
          if (s.bitCnt == `BYTE_BITS) begin
            n.sdaOe = 1'b1;
            n.state = PS_RX_ACK;
            if (s.firstByte) begin
              n.index = s.shift;
            end else begin
              n.index = idxInc;
              case (s.index)
                `IDX_ID:     n.idHigh = s.shift[6:1];
                `IDX_SRATE:  n.cfg.sampleDiv = s.shift;
                `IDX_FILTER: n.cfg.filterCfg = s.shift & `FILTER_MASK;
                `IDX_INTCFG: n.cfg.intCfg = s.shift & `INTCFG_MASK;
                `IDX_POWER:  n.cfg.powerCtl = s.shift;
                default: ;
              endcase
            end
          end
        end
        PS_RX_ACK: begin
          n.sdaOe     = 1'b0;
          n.bitCnt    = 4'h0;
          n.firstByte = 1'b0;
          n.state     = PS_RX;
        end
        PS_TX: begin
          if (s.bitCnt == `BYTE_BITS) begin
            n.sdaOe = 1'b0;
            n.state = PS_TX_ACK;
          end else begin
            n.txShift = {s.txShift[6:0], 1'b0};
            n.sdaOe   = ~s.txShift[6];
          end
        end
        PS_TX_ACK: begin
          n.bitCnt = 4'h0;
          if (s.hostAck) begin
            n.index   = idxInc;
            txByte    = readByte(s, sensor, idxInc);
            rdEv      = 1'b1;
            rdIdx     = idxInc;
            n.txShift = txByte;
            n.sdaOe   = ~txByte[7];
            n.state   = PS_TX;
          end else begin
            n.sdaOe = 1'b0;
            n.state = PS_WAIT;
          end
        end
        default: ;
      endcase
    end
    if (rdEv && (rdIdx == `IDX_FLAGS || s.cfg.intCfg[`ANYRD_BIT]))
      n.flags = 8'h00;
    if (dataReadyEvent && s.cfg.intCfg[`RAW_EN_BIT])
      n.flags[`RAW_FLAG_BIT] = 1'b1;
    if (pllReadyEvent && s.cfg.intCfg[`PLL_EN_BIT])
      n.flags[`PLL_FLAG_BIT] = 1'b1;
    // hold only once the controller has pulled the clock low itself
    n.sclOe = stretchRequest && s.busy && (s.sclOe || !sclNow);
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s         <= '0;
      s.sclSync <= 2'b11;
      s.sdaSync <= 2'b11;
      s.sclPrev <= 1'b1;
      s.sdaPrev <= 1'b1;
      s.idHigh  <= ID_HIGH_DEFAULT;
      s.cfg     <= {4{`CFG_RESET}};
    end else begin
      s <= n;
    end
  end

  assign sclOut         = 1'b0;
  assign sdaOut         = 1'b0;
  assign sclOe          = s.sclOe;
  assign sdaOe          = s.sdaOe;
  assign cfgOut         = s.cfg;
  assign interruptFlags = s.flags;
  assign busBusy        = s.busy;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  logic quiet;
  assign quiet = !startCond && !stopCond;

  a_start_framing: assert property (startCond |=> s.state == PS_ADDR && s.bitCnt == 4'h0 && s.busy)
    else $error("start did not reset framing");
  a_stop_frees: assert property (stopCond |=> !s.busy && s.state == PS_IDLE && !s.sdaOe)
    else $error("stop did not free the bus");
  a_byte_count: assert property (s.state == PS_TX || s.state == PS_RX |-> s.bitCnt <= `BYTE_BITS)
    else $error("byte longer than eight bits");
  a_addr_ack: assert property (sclFall && quiet && s.state == PS_ADDR && s.bitCnt == `BYTE_BITS
    && s.shift[7:1] == ownAddr |=> s.sdaOe && s.state == PS_ADDR_ACK)
    else $error("own address not acknowledged");
  a_other_addr: assert property (sclFall && quiet && s.state == PS_ADDR && s.bitCnt == `BYTE_BITS
    && s.shift[7:1] != ownAddr |=> !s.sdaOe && s.state == PS_IDLE)
    else $error("foreign address acknowledged");
  a_ack_held: assert property (s.state == PS_RX_ACK && !sclFall && quiet |=> s.sdaOe)
    else $error("acknowledge released early");
  a_nack_release: assert property (sclFall && quiet && s.state == PS_TX_ACK && !s.hostAck
    |=> !s.sdaOe ##1 !s.sdaOe)
    else $error("data held after not-acknowledge");
  a_read_advance: assert property (sclFall && quiet && s.state == PS_TX_ACK && s.hostAck
    |=> s.index == $past(idxInc) && s.state == PS_TX)
    else $error("read index did not advance");
  a_index_hold: assert property (s.index >= `IDX_HOLD_LO && s.index <= `IDX_HOLD_HI
    |-> idxInc == s.index)
    else $error("index moved inside reserved range");
  a_write_advance: assert property (sclFall && quiet && s.state == PS_RX && s.bitCnt == `BYTE_BITS
    && !s.firstByte |=> s.index == $past(idxInc) && s.state == PS_RX_ACK)
    else $error("write index did not advance");
  a_flag_clear: assert property (sclFall && quiet && s.state == PS_ADDR_ACK && s.rw
    && (s.index == `IDX_FLAGS || s.cfg.intCfg[`ANYRD_BIT]) && !dataReadyEvent && !pllReadyEvent
    |=> s.flags == 8'h00)
    else $error("flags not cleared by read");
  a_flag_set: assert property (dataReadyEvent && s.cfg.intCfg[`RAW_EN_BIT]
    |=> s.flags[`RAW_FLAG_BIT])
    else $error("data ready flag lost");
  a_stretch_cause: assert property (s.sclOe |-> $past(stretchRequest) && s.busy)
    else $error("clock held without request");

  c_write_byte: cover property (s.state == PS_RX_ACK && !s.firstByte);
  c_read_burst: cover property (sclFall && s.state == PS_TX_ACK && s.hostAck);
  c_read_end: cover property (s.state == PS_WAIT ##[1:1000] stopCond);
  c_stretch: cover property (s.sclOe [*4]);

endmodule
`default_nettype wire

//--- tb/i2c_host_model.sv
/*
  Behavioural two-wire bus controller that drives the register port.
  Assumes pull-ups on both lines and a 200 MHz sampling clock; a half
  link period is 8 sampling cycles, giving the 80 ns link clock.
*/
`timescale 1ns/1ps
`default_nettype none

module i2c_host_model (
  input  wire logic clk,      // sampling clock
  input  wire logic sclOe,    // device pulls clock low
  input  wire logic sdaOe,    // device pulls data low
  output logic      sclLine,  // resolved clock line
  output logic      sdaLine,  // resolved data line
  output var logic  stalled   // clock release timed out
);
  logic sclLow = 1'b0;
  logic sdaLow = 1'b0;
  logic stallSeen = 1'b0;

  // pull-ups: a released line reads high
  assign sclLine = ~(sclLow | sclOe);
  assign sdaLine = ~(sdaLow | sdaOe);
  assign stalled = stallSeen;

  // ---------------------------------------------------------------
  // bus primitives
  // ---------------------------------------------------------------
  task automatic half();
    repeat (8) @(posedge clk);
  endtask

  // release the clock and wait while the device stretches it
  task automatic rise();
    int n;
    n = 0;
    sclLow <= 1'b0;
    @(posedge clk);
    while (!sclLine && n < 4000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 4000) stallSeen = 1'b1;
    // high phase of eight sampling cycles, counting the edge above
    repeat (7) @(posedge clk);
  endtask

  // plain or repeated start
  task automatic start();
    sdaLow <= 1'b0;
    half();
    rise();
    sdaLow <= 1'b1;
    half();
    sclLow <= 1'b1;
    half();
  endtask

  task automatic stop();
    sdaLow <= 1'b1;
    half();
    rise();
    sdaLow <= 1'b0;
    half();
  endtask

  // eight bits msb first, then the acknowledge bit; a 1 releases data
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      repeat (2) @(posedge clk);
      sdaLow <= ~tx[i];
      // low phase of eight sampling cycles in all
      repeat (6) @(posedge clk);
      rise();
      rx[i] = sdaLine;
      sclLow <= 1'b1;
    end
    half();
  endtask
endmodule
`default_nettype wire

//--- tb/gyro_i2c_register_port_bench.sv
/*
  Self-checking bench of the rate-sensor two-wire register port.
  Assumes the package, the design and the host model compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "gyro_consts.svh"

module gyro_i2c_register_port_bench
  import gyro_pkg::*;
;
  localparam logic [5:0] ID_HI = 6'h2A;  // arbitrary identity value
  logic         clk_sys = 1'b0;
  logic         rst = 1'b1;
  logic         addressSelectPin = 1'b0;
  logic         stretchRequest = 1'b0;
  logic         dataReadyEvent = 1'b0;
  logic         pllReadyEvent = 1'b0;
  sensor_data_s sensor = '0;
  wire logic    sclLine, sdaLine, sclOe, sdaOe, busBusy, hostStalled;
  wire logic    sclDrv, sdaDrv;
  config_s      cfgOut;
  logic [7:0]   interruptFlags;
  logic         sawStretch = 1'b0;
  logic         resStb = 1'b0;
  logic [6:0]   tgt;
  logic [8:0]   rx;
  logic [31:0]  v, c, ex, resVal;
  logic [31:0]  expQ[$];
  int           badCount = 0;
  int           totalChecks = 0;

  gyro_i2c_register_port #(.ID_HIGH_DEFAULT(ID_HI)) dut (
    .clk_sys(clk_sys), .rst(rst), .sclIn(sclLine), .sclOut(sclDrv), .sclOe(sclOe),
    .sdaIn(sdaLine), .sdaOut(sdaDrv), .sdaOe(sdaOe), .addressSelectPin(addressSelectPin),
    .stretchRequest(stretchRequest), .sensor(sensor), .dataReadyEvent(dataReadyEvent),
    .pllReadyEvent(pllReadyEvent), .cfgOut(cfgOut), .interruptFlags(interruptFlags), .busBusy(busBusy));

  i2c_host_model host (.clk(clk_sys), .sclOe(sclOe), .sdaOe(sdaOe), .sclLine(sclLine),
                       .sdaLine(sdaLine), .stalled(hostStalled));

  always #2.5 clk_sys = ~clk_sys;

  always @(posedge clk_sys) begin
    if (sclOe === 1'b1) sawStretch <= 1'b1;
  end

  // results are compared with the oldest expectation
  always @(posedge clk_sys) begin
    if (resStb) begin
      totalChecks++;
      ex = (expQ.size() > 0) ? expQ.pop_front() : 32'hxxxx_xxxx;
      if (ex !== resVal) begin
        badCount++;
        $display("Error at %0t: expected %h got %h", $time, ex, resVal);
      end
    end
  end

  // ---------------------------------------------------------------
  // bench tasks
  // ---------------------------------------------------------------
  task automatic closeOut();
    $display("checks %0d mismatches %0d", totalChecks, badCount);
    if (badCount == 0 && totalChecks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    expQ.push_back(e);
    @(posedge clk_sys);
    resVal <= g;
    resStb <= 1'b1;
    @(posedge clk_sys);
    resStb <= 1'b0;
  endtask

  task automatic pulse(input logic [1:0] ev);
    @(posedge clk_sys);
    {pllReadyEvent, dataReadyEvent} <= ev;
    @(posedge clk_sys);
    {pllReadyEvent, dataReadyEvent} <= 2'b00;
    repeat (2) @(posedge clk_sys);
  endtask

  task automatic wr(input logic [7:0] idx, input int n, input logic [23:0] d);
    host.start();
    host.xfer({tgt, 1'b0, 1'b1}, rx);
    chk(32'h2, 32'({busBusy, rx[0]}));
    host.xfer({idx, 1'b1}, rx);
    chk(32'h0, 32'(rx[0]));
    for (int i = 0; i < n; i++) begin
      host.xfer({d[23-8*i -: 8], 1'b1}, rx);
      chk(32'h0, 32'(rx[0]));
    end
    host.stop();
  endtask

  task automatic rd(input logic [7:0] idx, input int n, input logic [23:0] e);
    host.start();
    host.xfer({tgt, 1'b0, 1'b1}, rx);
    host.xfer({idx, 1'b1}, rx);
    host.start();
    host.xfer({tgt, 1'b1, 1'b1}, rx);
    chk(32'h2, 32'({busBusy, rx[0]}));
    for (int i = 0; i < n; i++) begin
      host.xfer({8'hFF, i == n - 1}, rx);
      chk(32'(e[23-8*i -: 8]), 32'(rx[8:1]));
    end
    host.stop();
  endtask

  initial begin
    repeat (100000) @(posedge clk_sys);
    badCount++;
    closeOut();
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    v = $urandom(32'hfb14);
    tgt = {ID_HI, 1'b0};
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    sensor <= {$urandom, $urandom};
    repeat (6) @(posedge clk_sys);
    chk(32'h0, cfgOut);
    chk(32'h0, 32'({busBusy, interruptFlags, sclDrv, sdaDrv}));
    // repeated start to another target leaves the port silent
    host.start();
    host.xfer({tgt, 1'b0, 1'b1}, rx);
    host.xfer({`IDX_ID, 1'b1}, rx);
    host.start();
    host.xfer({tgt ^ 7'h01, 1'b1, 1'b1}, rx);
    chk(32'h1, 32'(rx[0]));
    host.xfer(9'h1FF, rx);
    chk(32'h1FF, 32'(rx));
    host.stop();
    v = $urandom;
    c = {v[23:16], v[15:8] & `FILTER_MASK, v[7:0] & `INTCFG_MASK, 8'h00};
    wr(`IDX_SRATE, 3, v[23:0]);
    chk(c, cfgOut);
    wr(`IDX_TEMP_H, 2, v[31:8]);
    wr(8'h40, 1, v[31:8]);
    chk(c, cfgOut);
    rd(`IDX_FILTER, 2, {c[23:8], 8'h00});
    rd(`IDX_TEMP_H, 3, {sensor.temp, sensor.rateX[15:8]});
    rd(`IDX_RZ_L, 3, {sensor.rateZ[7:0], 16'h0000});
    rd(`IDX_ID, 1, {1'b0, ID_HI, 1'b0, 16'h0000});
    wr(`IDX_INTCFG, 1, 24'h05_0000);
    pulse(2'b11);
    chk(32'h5, 32'(interruptFlags));
    // with clear_on_any_read off, reading another register keeps the flags
    rd(`IDX_INTCFG, 1, 24'h05_0000);
    chk(32'h5, 32'(interruptFlags));
    rd(`IDX_FLAGS, 1, 24'h05_0000);
    chk(32'h0, 32'(interruptFlags));
    wr(`IDX_INTCFG, 1, 24'h11_0000);
    c[15:8] = 8'h11;
    pulse(2'b11);
    chk(32'h1, 32'(interruptFlags));
    rd(`IDX_SRATE, 1, {c[31:24], 16'h0000});
    chk(32'h0, 32'(interruptFlags));
    addressSelectPin <= 1'b1;
    tgt = {ID_HI, 1'b1};
    fork
      wr(`IDX_POWER, 1, {v[31:24], 16'h0000});
      begin
        repeat (300) @(posedge clk_sys);
        stretchRequest <= 1'b1;
        repeat (200) @(posedge clk_sys);
        stretchRequest <= 1'b0;
      end
    join
    chk({c[31:8], v[31:24]}, cfgOut);
    chk(32'h1, 32'(sawStretch));
    chk(32'h0, 32'({hostStalled, busBusy}));
    repeat (2) @(posedge clk_sys);
    closeOut();
  end
endmodule
`default_nettype wire
